// [verilog/bmps_pkg.sv]
// Purpose: shared constants and types of the boot mode and pin sharing block
// Assumes: 32-bit AHB-Lite register bus, one clock
// Notes:   offsets are byte addresses, one aligned word per register
package bmps_pkg;

  localparam int ADDR_W = 14;   // full mode address width
  localparam int DATA_W = 24;   // external data width
  localparam int BYTE_W = 8;    // byte address bits on the data msbs
  localparam int HP_W   = 16;   // host port width
  localparam int FLAG_N = 8;    // shared flag pins
  localparam int SP_N   = 5;    // second serial port pins
  localparam int IRQ_N  = 6;    // interrupt status bits

  // register offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DIR   = 8'h04;
  localparam logic [7:0] OFS_FOUT  = 8'h08;
  localparam logic [7:0] OFS_FIN   = 8'h0c;
  localparam logic [7:0] OFS_MODE  = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;
  localparam logic [7:0] OFS_MASK  = 8'h18;

  // reset values
  localparam logic              CTRL_RST = 1'b1;   // serial port function
  localparam logic [FLAG_N-1:0] DIR_RST  = 8'h00;  // all flags inputs
  localparam logic [FLAG_N:0]   FOUT_RST = 9'h000;
  localparam logic [IRQ_N-1:0]  MASK_RST = 6'h00;
  localparam logic [IRQ_N-1:0]  STAT_RST = 6'h00;

  // field positions
  localparam int MODE_C_BIT    = 2;  // memory mode pin among the mode pins
  localparam int MODE_N        = 3;  // mode pins share flags 2..0
  localparam int SHARED_PF_LO  = 4;  // flags 4..7 also carry interrupts
  localparam int STAT_SP_IRQ0  = 4;
  localparam int STAT_SP_IRQ1  = 5;
  localparam int SP_IRQ0_PIN   = 0;
  localparam int SP_IRQ1_PIN   = 1;
  localparam int SP_FI_PIN     = 2;
  localparam int SP_FO_PIN     = 3;
  localparam int FOUT_SP_BIT   = 8;  // serial flag output in flag out reg
  localparam int FIN_SP_BIT    = 8;  // serial flag input in flag in reg
  localparam int MODE_HOST_BIT = 3;  // decoded mode in mode reg
  localparam int MODE_DONE_BIT = 4;

  typedef enum logic {
    BMPS_MEM_FULL = 1'b0,
    BMPS_MEM_HOST = 1'b1
  } bmps_mem_mode_t;

  typedef enum logic {
    BMPS_CAP_WAIT = 1'b0,
    BMPS_CAP_DONE = 1'b1
  } bmps_cap_t;

  // core side of the external memory bus
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              drive;
    logic              byte_acc;
    logic [BYTE_W-1:0] byte_addr;
  } bmps_core_bus_t;

  // pin side of the external memory bus
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] doe;
  } bmps_ext_bus_t;

endpackage

// [verilog/bmps_pin_mux.sv]
// Purpose: reset-time memory mode capture and shared pin multiplexing
// Assumes: all pin inputs synchronous to CLOCK; zero wait AHB-Lite slave
// Notes:   interrupt pins are active low; status bits clear by writing one
`timescale 1ns/1ps

module bmps_pin_mux
  import bmps_pkg::*;
(
  input  wire logic                 CLOCK,
  input  wire logic                 RESETN,
  // ahb-lite slave
  input  wire logic                 HSEL,
  input  wire logic [31:0]          HADDR,
  input  wire logic [1:0]           HTRANS,
  input  wire logic                 HWRITE,
  input  wire logic [2:0]           HSIZE,
  input  wire logic [31:0]          HWDATA,
  input  wire logic                 HREADY,
  output logic      [31:0]          HRDATA,
  output logic                      HREADYOUT,
  output logic                      HRESP,
  output logic                      IRQ,
  // shared flag pins, mode pins on 2..0
  input  wire logic [FLAG_N-1:0]    PF_I,
  output logic      [FLAG_N-1:0]    PF_O,
  output logic      [FLAG_N-1:0]    PF_OE,
  // second serial port pins and its core side
  input  wire logic [SP_N-1:0]      SP1_I,
  output logic      [SP_N-1:0]      SP1_O,
  output logic      [SP_N-1:0]      SP1_OE,
  input  wire logic [SP_N-1:0]      SPORT_O,
  input  wire logic [SP_N-1:0]      SPORT_OE,
  output logic      [SP_N-1:0]      SPORT_I,
  // external memory bus
  input  wire bmps_core_bus_t       CORE_BUS,
  output bmps_ext_bus_t             EXT_BUS,
  input  wire logic [DATA_W-1:0]    EXT_D_I,
  output logic      [DATA_W-1:0]    CORE_RDATA,
  // host port pins and core side
  input  wire logic [HP_W-1:0]      HP_AD_I,
  output logic      [HP_W-1:0]      HP_AD_O,
  output logic                      HP_AD_OE,
  input  wire logic                 HP_WR_N,
  input  wire logic                 HP_RD_N,
  input  wire logic                 HP_AL,
  input  wire logic                 HP_CS_N,
  output logic                      HP_ACK_N,
  output logic      [HP_W-1:0]      HOST_ADDR,
  output logic      [HP_W-1:0]      HOST_WDATA,
  output logic                      HOST_WR,
  input  wire logic [HP_W-1:0]      HOST_RDATA,
  output logic                      HOST_MODE
);

  ////////////////////////////////////////////////////////////////////////////
  // mode capture

  bmps_cap_t           cap_reg,  cap_next;
  logic [MODE_N-1:0]   mode_reg, mode_next;
  logic                host;

  // latch at release
  // an async reset may only load constants, so the pins are caught by the
  // first clock after release while the flag drivers are still off
  always_comb begin
    cap_next  = cap_reg;
    mode_next = mode_reg;
    case (cap_reg)
      BMPS_CAP_WAIT: begin
        mode_next = PF_I[MODE_N-1:0];
        cap_next  = BMPS_CAP_DONE;
      end
      default: begin
        mode_next = mode_reg;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cap_reg  <= BMPS_CAP_WAIT;
      mode_reg <= '0;
    end else begin
      cap_reg  <= cap_next;
      mode_reg <= mode_next;
    end
  end

  assign host      = (mode_reg[MODE_C_BIT] == BMPS_MEM_HOST);
  assign HOST_MODE = host;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave

  logic              ctrl_reg, ctrl_next;     // 1: serial port function
  logic [FLAG_N-1:0] dir_reg,  dir_next;      // 1: flag drives its pin
  logic [FLAG_N:0]   fout_reg, fout_next;
  logic [IRQ_N-1:0]  mask_reg, mask_next;
  logic [IRQ_N-1:0]  stat_reg, stat_next;
  logic [7:0]        wadr_reg, wadr_next;
  logic              wr_reg,   wr_next;
  logic [31:0]       rdat_reg, rdat_next;
  logic [FLAG_N-1:0] pf_level;
  logic [FLAG_N:0]   fin;
  logic [IRQ_N-1:0]  event_vec;
  logic              aphase;

  assign aphase    = HSEL && HTRANS[1] && HREADY;
  assign HREADYOUT = 1'b1;   // never waits
  assign HRESP     = 1'b0;   // always okay
  assign HRDATA    = rdat_reg;
  assign fin       = {SP1_I[SP_FI_PIN], pf_level};

  // address decode; read data staged for the data phase
  always_comb begin
    wadr_next = wadr_reg;
    wr_next   = 1'b0;
    rdat_next = rdat_reg;
    if (aphase) begin
      wadr_next = HADDR[7:0];
      wr_next   = HWRITE;
      rdat_next = '0;
      if (!HWRITE) begin
        if (HADDR[7:0] == OFS_CTRL) begin
          rdat_next[0] = ctrl_reg;
        end else if (HADDR[7:0] == OFS_DIR) begin
          rdat_next[FLAG_N-1:0] = dir_reg;
        end else if (HADDR[7:0] == OFS_FOUT) begin
          rdat_next[FLAG_N:0] = fout_reg;
        end else if (HADDR[7:0] == OFS_FIN) begin
          rdat_next[FLAG_N:0] = fin;
        end else if (HADDR[7:0] == OFS_MODE) begin
          rdat_next[MODE_N-1:0]   = mode_reg;
          rdat_next[MODE_HOST_BIT] = host;
          rdat_next[MODE_DONE_BIT] = (cap_reg == BMPS_CAP_DONE);
        end else if (HADDR[7:0] == OFS_STAT) begin
          rdat_next[IRQ_N-1:0] = stat_reg;
        end else if (HADDR[7:0] == OFS_MASK) begin
          rdat_next[IRQ_N-1:0] = mask_reg;
        end
      end
    end
  end

  // register writes in the data phase; events win over a clearing write
  always_comb begin
    ctrl_next = ctrl_reg;
    dir_next  = dir_reg;
    fout_next = fout_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (wr_reg) begin
      if (wadr_reg == OFS_CTRL) begin
        ctrl_next = HWDATA[0];
      end else if (wadr_reg == OFS_DIR) begin
        dir_next = HWDATA[FLAG_N-1:0];
      end else if (wadr_reg == OFS_FOUT) begin
        fout_next = HWDATA[FLAG_N:0];
      end else if (wadr_reg == OFS_STAT) begin
        stat_next = stat_reg & ~HWDATA[IRQ_N-1:0];
      end else if (wadr_reg == OFS_MASK) begin
        mask_next = HWDATA[IRQ_N-1:0];
      end
    end
    stat_next = stat_next | event_vec;
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_reg <= CTRL_RST;
      dir_reg  <= DIR_RST;
      fout_reg <= FOUT_RST;
      mask_reg <= MASK_RST;
      stat_reg <= STAT_RST;
      wadr_reg <= '0;
      wr_reg   <= 1'b0;
      rdat_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      dir_reg  <= dir_next;
      fout_reg <= fout_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      wadr_reg <= wadr_next;
      wr_reg   <= wr_next;
      rdat_reg <= rdat_next;
    end
  end

  assign IRQ = |(stat_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // flag pins and interrupt events

  genvar g;
  generate
    for (g = 0; g < FLAG_N; g++) begin : g_pf
      if (g < MODE_N) begin : g_mode
        // mode pins quiet in reset
        // driver off until capture so the strap level is what is sampled
        assign PF_OE[g] = dir_reg[g] && (cap_reg == BMPS_CAP_DONE);
      end else begin : g_plain
        assign PF_OE[g] = dir_reg[g];
      end
      assign PF_O[g] = fout_reg[g];
      assign pf_level[g] = PF_OE[g] ? PF_O[g] : PF_I[g];
      if (g >= SHARED_PF_LO) begin : g_irq
        assign event_vec[g - SHARED_PF_LO] = !pf_level[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // second serial port

  always_comb begin
    SP1_O   = SPORT_O;
    SP1_OE  = SPORT_OE;
    SPORT_I = SP1_I;
    if (!ctrl_reg) begin
      SP1_OE[SP_IRQ0_PIN] = 1'b0;
      SP1_OE[SP_IRQ1_PIN] = 1'b0;
      SP1_OE[SP_FI_PIN]   = 1'b0;
      SP1_O[SP_FO_PIN]    = fout_reg[FOUT_SP_BIT];
      SP1_OE[SP_FO_PIN]   = 1'b1;
      SPORT_I[SP_IRQ0_PIN] = 1'b1;   // idle level to the serial core
      SPORT_I[SP_IRQ1_PIN] = 1'b1;
      SPORT_I[SP_FI_PIN]   = 1'b1;
    end
  end

  assign event_vec[STAT_SP_IRQ0] = !ctrl_reg && !SP1_I[SP_IRQ0_PIN];
  assign event_vec[STAT_SP_IRQ1] = !ctrl_reg && !SP1_I[SP_IRQ1_PIN];

  ////////////////////////////////////////////////////////////////////////////
  // external memory bus

  bmps_ext_bus_t     ext_reg,  ext_next;
  logic [DATA_W-1:0] crd_reg,  crd_next;

  always_comb begin
    ext_next = '0;
    crd_next = EXT_D_I;
    if (!host) begin
      ext_next.addr  = CORE_BUS.addr;
      ext_next.dout  = CORE_BUS.wdata;
      ext_next.doe   = {DATA_W{CORE_BUS.drive}};
      if (CORE_BUS.byte_acc) begin
        // byte address rides on the data msbs
        ext_next.dout[DATA_W-1 -: BYTE_W] = CORE_BUS.byte_addr;
        ext_next.doe[DATA_W-1 -: BYTE_W]  = {BYTE_W{1'b1}};
      end
    end else begin
      // one address bit, upper data
      // peripherals beyond two words need outside latches on the selects
      ext_next.addr[0] = CORE_BUS.addr[0];
      ext_next.dout[DATA_W-1 -: HP_W] = CORE_BUS.wdata[HP_W-1:0];
      ext_next.doe[DATA_W-1 -: HP_W]  = {HP_W{CORE_BUS.drive}};
      crd_next = {{(DATA_W-HP_W){1'b0}}, EXT_D_I[DATA_W-1 -: HP_W]};
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ext_reg <= '0;
      crd_reg <= '0;
    end else begin
      ext_reg <= ext_next;
      crd_reg <= crd_next;
    end
  end

  assign EXT_BUS    = ext_reg;
  assign CORE_RDATA = crd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // host port

  logic [HP_W-1:0] hadr_reg, hadr_next;
  logic [HP_W-1:0] hwd_reg,  hwd_next;
  logic [HP_W-1:0] hrd_reg,  hrd_next;
  logic            hwl_reg,  hwl_next;   // write strobe seen low
  logic            hsel;

  assign hsel = host && !HP_CS_N;

  // host port only in host mode
  always_comb begin
    hadr_next = hadr_reg;
    hwd_next  = hwd_reg;
    hrd_next  = HOST_RDATA;
    hwl_next  = hsel && !HP_WR_N;
    if (hsel && HP_AL) begin
      hadr_next = HP_AD_I;
    end
    if (hsel && !HP_WR_N) begin
      hwd_next = HP_AD_I;
    end
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      hadr_reg <= '0;
      hwd_reg  <= '0;
      hrd_reg  <= '0;
      hwl_reg  <= 1'b0;
    end else begin
      hadr_reg <= hadr_next;
      hwd_reg  <= hwd_next;
      hrd_reg  <= hrd_next;
      hwl_reg  <= hwl_next;
    end
  end

  // write completes on the rising edge of the strobe
  assign HOST_WR    = hwl_reg && !hwl_next;
  assign HOST_ADDR  = hadr_reg;
  assign HOST_WDATA = hwd_reg;
  assign HP_AD_O    = hrd_reg;
  assign HP_AD_OE   = hsel && !HP_RD_N;
  assign HP_ACK_N   = !(hsel && (!HP_RD_N || !HP_WR_N));

endmodule

// [verification/bmps_chk.sv]
// Purpose: port checker for bmps_pin_mux
// Assumes: one clock, async active low reset
// Notes:   a small edge counter tracks mode capture
`timescale 1ns/1ps
module bmps_chk
  import bmps_pkg::*;
(
  input wire logic              CLOCK,
  input wire logic              RESETN,
  input wire logic [FLAG_N-1:0] PF_I,
  input wire logic [FLAG_N-1:0] PF_OE,
  input wire logic              HP_CS_N,
  input wire logic              HP_RD_N,
  input wire logic              HP_WR_N,
  input wire logic              HP_ACK_N,
  input wire logic              HP_AD_OE,
  input wire bmps_core_bus_t    CORE_BUS,
  input wire bmps_ext_bus_t     EXT_BUS,
  input wire logic              HOST_MODE
);
  logic [1:0] edge_reg;
  logic [1:0] edge_next;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////////
  // edges since reset, saturating at 3 once the mode is settled
  always_comb edge_next = (edge_reg == 2'h3) ? edge_reg : edge_reg + 2'h1;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) edge_reg <= 2'h0;
    else edge_reg <= edge_next;
  end
  sequence s_cap;
    edge_reg == 2'h1;
  endsequence
  sequence s_run;
    edge_reg == 2'h3;
  endsequence
  ////////////////////////////////////////////////////////////////
  property p_mode_cap;
    s_cap |-> HOST_MODE == $past(PF_I[MODE_C_BIT]);
  endproperty
  a_mode_cap: assert property (p_mode_cap) else $error("mode not latched");
  property p_mode_hold;
    s_run |-> $stable(HOST_MODE);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
  property p_pf_oe;
    edge_reg == 2'h0 |-> PF_OE[MODE_N-1:0] == '0;
  endproperty
  a_pf_oe: assert property (p_pf_oe) else $error("mode pin driven");
  property p_ack;
    HOST_MODE && !HP_CS_N && (!HP_RD_N || !HP_WR_N) |-> !HP_ACK_N;
  endproperty
  a_ack: assert property (p_ack) else $error("no host ack");
  property p_ack_full;
    !HOST_MODE |-> HP_ACK_N && !HP_AD_OE;
  endproperty
  a_ack_full: assert property (p_ack_full) else $error("host port live");
  property p_ext_full;
    s_run ##0 !HOST_MODE |=> EXT_BUS.addr == $past(CORE_BUS.addr);
  endproperty
  a_ext_full: assert property (p_ext_full) else $error("full address");
  property p_byte;
    s_run ##0 (!HOST_MODE && CORE_BUS.byte_acc)
      |=> EXT_BUS.dout[23:16] == $past(CORE_BUS.byte_addr);
  endproperty
  a_byte: assert property (p_byte) else $error("byte address");
  property p_host;
    s_run ##0 HOST_MODE |=> EXT_BUS.addr[ADDR_W-1:1] == '0 && EXT_BUS.doe[7:0] == '0;
  endproperty
  a_host: assert property (p_host) else $error("host bus shape");
endmodule
bind bmps_pin_mux bmps_chk u_chk (.CLOCK, .RESETN, .PF_I, .PF_OE, .HP_CS_N, .HP_RD_N,
  .HP_WR_N, .HP_ACK_N, .HP_AD_OE, .CORE_BUS, .EXT_BUS, .HOST_MODE);

// [verification/bmps_strap.sv]
// Purpose: flag pin wires with mode strap driver and pulls
// Assumes: a pull resistor sits on every flag pin
// Notes:   strap enable lags reset by one flop
`timescale 1ns/1ps
module bmps_strap
  import bmps_pkg::*;
(
  input wire logic              CLOCK,
  input wire logic              RESETN,
  input wire logic [2:0]        MODE,
  input wire logic [FLAG_N-1:0] PULL,
  input wire logic [FLAG_N-1:0] PF_O,
  input wire logic [FLAG_N-1:0] PF_OE,
  output logic     [FLAG_N-1:0] PF_I
);
  logic drv_en;
  // strap released after reset
  // flop delay keeps the strap valid at the capture edge
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) drv_en <= 1'b1;
    else drv_en <= 1'b0;
  end
  // wire level: device first, then strap, else the pull
  always_comb begin
    PF_I = PULL;
    for (int i = 0; i < FLAG_N; i++) begin
      if (PF_OE[i]) PF_I[i] = PF_O[i];
      else if (drv_en && i < MODE_N) PF_I[i] = MODE[i];
    end
  end
endmodule

// [verification/bmps_pin_mux_tb.sv]
// Purpose: self-checking bench for bmps_pin_mux
// Assumes: zero-wait slave, pull-ups on flag pins
// Notes:   a second reset moves the strap to host mode
`timescale 1ns/1ps
module bmps_pin_mux_tb
  import bmps_pkg::*;
;
  logic CLOCK, RESETN, HSEL, HWRITE, HP_WR_N, HP_RD_N, HP_AL, HP_CS_N;
  logic HREADYOUT, HRESP, IRQ, HP_AD_OE, HP_ACK_N, HOST_WR, HOST_MODE;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE, mode;
  wire HREADY;
  logic [FLAG_N-1:0] PF_I, PF_O, PF_OE, pull;
  logic [SP_N-1:0] SP1_I, SP1_O, SP1_OE, SPORT_O, SPORT_OE, SPORT_I;
  bmps_core_bus_t CORE_BUS;
  bmps_ext_bus_t EXT_BUS;
  logic [DATA_W-1:0] EXT_D_I, CORE_RDATA;
  logic [HP_W-1:0] HP_AD_I, HP_AD_O, HOST_ADDR, HOST_WDATA, HOST_RDATA;
  int err_count, n_compared;
  assign HREADY = HREADYOUT;
  bmps_pin_mux DUT (.CLOCK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .IRQ, .PF_I, .PF_O, .PF_OE, .SP1_I, .SP1_O,
    .SP1_OE, .SPORT_O, .SPORT_OE, .SPORT_I, .CORE_BUS, .EXT_BUS, .EXT_D_I, .CORE_RDATA,
    .HP_AD_I, .HP_AD_O, .HP_AD_OE, .HP_WR_N, .HP_RD_N, .HP_AL, .HP_CS_N, .HP_ACK_N,
    .HOST_ADDR, .HOST_WDATA, .HOST_WR, .HOST_RDATA, .HOST_MODE);
  bmps_strap u_strap (.CLOCK, .RESETN, .MODE(mode), .PULL(pull), .PF_O, .PF_OE, .PF_I);
  ////////////////////////////////////////////////////////////////
  // clock and watchdog, far beyond the under a hundred cycles used
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  initial begin
    #2000000;
    err_count++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  task automatic ck(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask
  // one ahb single transfer, held until hready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HADDR <= {24'h000000, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= wd;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask
  task automatic rck(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(a, 1'b0, 32'h0);
    ck(what, exp, rd);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask
  task automatic do_reset(input logic [2:0] m);
    mode <= m;
    RESETN <= 1'b0;
    tick(5);
    RESETN <= 1'b1;
    tick(2);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {err_count, n_compared} = '0;
    {RESETN, HSEL, HWRITE, HP_AL, HTRANS, HADDR, HWDATA, HP_AD_I} = '0;
    {HP_WR_N, HP_RD_N, HP_CS_N} = 3'h7;
    {HSIZE, mode, pull, SP1_I} = {3'h2, 3'h2, 8'hff, 5'h1f};
    {SPORT_O, SPORT_OE, CORE_BUS, EXT_D_I} = {5'h0a, 5'h1c, 48'h0, 24'h0};
    HOST_RDATA = 16'h7777;
    do_reset(3'h2);
    rck(OFS_MODE, 32'h12, "mode");
    rck(OFS_CTRL, 32'h1, "ctrl");
    ck("hresp", 32'h0, 32'(HRESP));
    ck("full mode", 32'h0, 32'(HOST_MODE));
    rck(8'h1c, 32'h0, "unmapped");
    $display("test reset done");
    bus(OFS_FOUT, 1'b1, 32'h005);
    bus(OFS_DIR, 1'b1, 32'h0f);
    tick(1);
    ck("pf_oe", 32'h0f, 32'(PF_OE));
    rck(OFS_FIN, 32'h1f5, "fin");
    $display("test flags done");
    bus(OFS_MASK, 1'b1, 32'h11);
    bus(OFS_DIR, 1'b1, 32'h1f);
    tick(2);
    ck("irq self", 32'h1, 32'(IRQ));
    bus(OFS_DIR, 1'b1, 32'h0f);
    bus(OFS_STAT, 1'b1, 32'h01);
    rck(OFS_STAT, 32'h0, "stat clr");
    pull <= 8'hdf;
    tick(2);
    ck("irq masked", 32'h0, 32'(IRQ));
    rck(OFS_STAT, 32'h02, "stat pf5");
    pull <= 8'hff;
    $display("test irq done");
    ck("sp1 oe", 32'(SPORT_OE), 32'(SP1_OE));
    ck("sp1 o", 32'h0a, 32'(SP1_O));
    bus(OFS_FOUT, 1'b1, 32'h105);
    bus(OFS_CTRL, 1'b1, 32'h0);
    tick(1);
    ck("sp1 flag oe", 32'h18, 32'(SP1_OE));
    ck("sp1 fo", 32'h1, 32'(SP1_O[SP_FO_PIN]));
    ck("irq idle", 32'h0, 32'(IRQ));
    SP1_I <= 5'h1e;
    tick(2);
    ck("irq sp", 32'h1, 32'(IRQ));
    ck("sport i", 32'h1f, 32'(SPORT_I));
    $display("test serial done");
    CORE_BUS <= '{14'h2abc, 24'h123456, 1'b1, 1'b1, 8'h5a};
    EXT_D_I <= 24'hab12cd;
    tick(2);
    ck("ext addr", 32'h2abc, 32'(EXT_BUS.addr));
    ck("ext data", 32'h5a3456, 32'(EXT_BUS.dout));
    ck("core rdata", 32'hab12cd, 32'(CORE_RDATA));
    ck("ext byte", 32'h5a, 32'(EXT_BUS.dout[23:16]));
    do_reset(3'h4);
    rck(OFS_MODE, 32'h1c, "mode host");
    ck("host mode", 32'h1, 32'(HOST_MODE));
    CORE_BUS <= '{14'h2abd, 24'h00cafe, 1'b1, 1'b0, 8'h00};
    tick(2);
    ck("host a0", 32'h1, 32'(EXT_BUS.addr));
    ck("host d", 32'hcafe, 32'(EXT_BUS.dout[23:8]));
    ck("host rdata", 32'h00ab12, 32'(CORE_RDATA));
    HP_CS_N <= 1'b0;
    HP_AL <= 1'b1;
    HP_AD_I <= 16'h1234;
    tick(1);
    HP_AL <= 1'b0;
    HP_WR_N <= 1'b0;
    HP_AD_I <= 16'hbeef;
    tick(3);
    ck("ack", 32'h0, 32'(HP_ACK_N));
    HP_WR_N <= 1'b1;
    for (int i = 0; i < 8 && HOST_WR !== 1'b1; i++) @(negedge CLOCK);
    ck("host wr", 32'h1, 32'(HOST_WR));
    ck("host addr", 32'h1234, 32'(HOST_ADDR));
    ck("host data", 32'hbeef, 32'(HOST_WDATA));
    @(posedge CLOCK);
    HP_RD_N <= 1'b0;
    tick(2);
    ck("host rd", 32'h17777, {15'h0, HP_AD_OE, HP_AD_O});
    $display("test host done");
    close_out();
  end
endmodule
